// ==== core/cbt_defines.vh ====
// constants for the instruction length and machine-cycle timing block
`ifndef CBT_DEFINES_VH
`define CBT_DEFINES_VH

// core clocks per machine cycle, as the last phase index
`define CBT_PHASE_LAST 2'h3
`define CBT_PC_RESET 16'h0000

// instruction classes presented on the class input
`define CBT_C_IDLE 6'h00
`define CBT_C_XDATA 6'h01
`define CBT_C_EXT_POINTER_REGISTER_IMM 6'h02
`define CBT_C_CODE_EXT_POINTER_REGISTER 6'h03
`define CBT_C_CODE_PC 6'h04
`define CBT_C_MOV_A_REG 6'h05
`define CBT_C_MOV_A_DIR 6'h06
`define CBT_C_MOV_DIR_REG 6'h07
`define CBT_C_MOV_DIR_DIR 6'h08
`define CBT_C_MOV_IMM_REG 6'h09
`define CBT_C_STACK 6'h0A
`define CBT_C_SWAP_REG 6'h0B
`define CBT_C_SWAP_DIR 6'h0C
`define CBT_C_BIT_TO_C 6'h0D
`define CBT_C_C_TO_BIT 6'h0E
`define CBT_C_BIT_LOGIC 6'h0F
`define CBT_C_CARRY_OP 6'h10
`define CBT_C_BIT_OP 6'h11
`define CBT_C_JC 6'h12
`define CBT_C_JNC 6'h13
`define CBT_C_JB 6'h14
`define CBT_C_JNB 6'h15
`define CBT_C_JBC 6'h16
`define CBT_C_SCALL 6'h17
`define CBT_C_LONG_CALL 6'h18
`define CBT_C_SUB_EXIT 6'h19
`define CBT_C_INT_EXIT 6'h1A
`define CBT_C_RELATIVE_BRANCH_ABS 6'h1B
`define CBT_C_LONG_BRANCH 6'h1C
`define CBT_C_REL_JMP 6'h1D
`define CBT_C_IDX_JMP 6'h1E
`define CBT_C_JZ 6'h1F
`define CBT_C_JNZ 6'h20
`define CBT_C_CMP_BR 6'h21
`define CBT_C_COUNT_DOWN_BRANCH_REG 6'h22
`define CBT_C_COUNT_DOWN_BRANCH_DIR 6'h23

// lengths in bytes and machine cycles
`define CBT_LEN1 2'h1
`define CBT_LEN2 2'h2
`define CBT_LEN3 2'h3
`define CBT_MC1 2'h1
`define CBT_MC2 2'h2

// target kinds
`define CBT_T_NONE 3'h0
`define CBT_T_REL 3'h1
`define CBT_T_ABS11 3'h2
`define CBT_T_ABS16 3'h3
`define CBT_T_IDX 3'h4
`define CBT_T_RET 3'h5

// branch conditions
`define CBT_K_NEVER 4'h0
`define CBT_K_ALWAYS 4'h1
`define CBT_K_CARRY 4'h2
`define CBT_K_NCARRY 4'h3
`define CBT_K_BIT 4'h4
`define CBT_K_NBIT 4'h5
`define CBT_K_ZERO 4'h6
`define CBT_K_NZERO 4'h7
`define CBT_K_NEQ 4'h8
`define CBT_K_COUNT_DOWN_BRANCH 4'h9

// operand value that decrements to zero
`define CBT_COUNT_DOWN_BRANCH_LAST 8'h01
`define CBT_ZERO8 8'h00

`endif

// ==== core/cbt_decode.v ====
// class decoder: byte length, machine cycles, target kind and condition
`timescale 1ns/10ps
`default_nettype none
`include "cbt_defines.vh"
module cbt_decode (
    // class in
    input wire [5:0] insn_class,
    // decoded timing and flow
    output reg [1:0] len,
    output reg [1:0] cycles,
    output reg [2:0] tgt_kind,
    output reg [3:0] cond,
    output reg known
);
always @* begin
    len = `CBT_LEN1;
    cycles = `CBT_MC1;
    tgt_kind = `CBT_T_NONE;
    cond = `CBT_K_NEVER;
    known = 1'b1;
    case (insn_class)
        `CBT_C_IDLE: begin
            len = `CBT_LEN1;
        end
        `CBT_C_XDATA: begin
            cycles = `CBT_MC2;
        end
        `CBT_C_EXT_POINTER_REGISTER_IMM: begin
            len = `CBT_LEN3;
            cycles = `CBT_MC2;
        end
        `CBT_C_CODE_EXT_POINTER_REGISTER, `CBT_C_CODE_PC: begin
            cycles = `CBT_MC2;
        end
        `CBT_C_MOV_A_REG: begin
            len = `CBT_LEN1;
        end
        `CBT_C_MOV_A_DIR: begin
            len = `CBT_LEN2;
        end
        `CBT_C_MOV_DIR_REG: begin
            len = `CBT_LEN2;
            cycles = `CBT_MC2;
        end
        `CBT_C_MOV_DIR_DIR: begin
            len = `CBT_LEN3;
            cycles = `CBT_MC2;
        end
        `CBT_C_MOV_IMM_REG: begin
            len = `CBT_LEN2;
        end
        `CBT_C_STACK: begin
            len = `CBT_LEN2;
            cycles = `CBT_MC2;
        end
        `CBT_C_SWAP_REG: begin
            len = `CBT_LEN1;
        end
        `CBT_C_SWAP_DIR: begin
            len = `CBT_LEN2;
        end
        `CBT_C_BIT_TO_C: begin
            len = `CBT_LEN2;
        end
        `CBT_C_C_TO_BIT: begin
            len = `CBT_LEN2;
            cycles = `CBT_MC2;
        end
        `CBT_C_BIT_LOGIC: begin
            len = `CBT_LEN2;
            cycles = `CBT_MC2;
        end
        `CBT_C_CARRY_OP: begin
            len = `CBT_LEN1;
        end
        `CBT_C_BIT_OP: begin
            len = `CBT_LEN2;
        end
        `CBT_C_JC, `CBT_C_JNC: begin
            len = `CBT_LEN2;
            cycles = `CBT_MC2;
            tgt_kind = `CBT_T_REL;
            cond = (insn_class == `CBT_C_JC) ? `CBT_K_CARRY : `CBT_K_NCARRY;
        end
        `CBT_C_JB, `CBT_C_JBC: begin
            len = `CBT_LEN3;
            cycles = `CBT_MC2;
            tgt_kind = `CBT_T_REL;
            cond = `CBT_K_BIT;
        end
        `CBT_C_JNB: begin
            len = `CBT_LEN3;
            cycles = `CBT_MC2;
            tgt_kind = `CBT_T_REL;
            cond = `CBT_K_NBIT;
        end
        `CBT_C_SCALL, `CBT_C_RELATIVE_BRANCH_ABS: begin
            len = `CBT_LEN2;
            cycles = `CBT_MC2;
            tgt_kind = `CBT_T_ABS11;
            cond = `CBT_K_ALWAYS;
        end
        `CBT_C_LONG_CALL, `CBT_C_LONG_BRANCH: begin
            len = `CBT_LEN3;
            cycles = `CBT_MC2;
            tgt_kind = `CBT_T_ABS16;
            cond = `CBT_K_ALWAYS;
        end
        `CBT_C_SUB_EXIT, `CBT_C_INT_EXIT: begin
            len = `CBT_LEN1;
            cycles = `CBT_MC2;
            tgt_kind = `CBT_T_RET;
            cond = `CBT_K_ALWAYS;
        end
        `CBT_C_REL_JMP: begin
            len = `CBT_LEN2;
            cycles = `CBT_MC2;
            tgt_kind = `CBT_T_REL;
            cond = `CBT_K_ALWAYS;
        end
        `CBT_C_IDX_JMP: begin
            len = `CBT_LEN1;
            cycles = `CBT_MC2;
            tgt_kind = `CBT_T_IDX;
            cond = `CBT_K_ALWAYS;
        end
        `CBT_C_JZ, `CBT_C_JNZ: begin
            len = `CBT_LEN2;
            cycles = `CBT_MC2;
            tgt_kind = `CBT_T_REL;
            cond = (insn_class == `CBT_C_JZ) ? `CBT_K_ZERO : `CBT_K_NZERO;
        end
        `CBT_C_CMP_BR: begin
            len = `CBT_LEN3;
            cycles = `CBT_MC2;
            tgt_kind = `CBT_T_REL;
            cond = `CBT_K_NEQ;
        end
        `CBT_C_COUNT_DOWN_BRANCH_REG, `CBT_C_COUNT_DOWN_BRANCH_DIR: begin
            len = (insn_class == `CBT_C_COUNT_DOWN_BRANCH_REG) ? `CBT_LEN2 : `CBT_LEN3;
            cycles = `CBT_MC2;
            tgt_kind = `CBT_T_REL;
            cond = `CBT_K_COUNT_DOWN_BRANCH;
        end
        default: begin
            // unknown class runs as a one-byte, one-cycle idle
            known = 1'b0;
        end
    endcase
end
endmodule
`default_nettype wire

// ==== core/cbt_mc_timer.v ====
// machine-cycle timer: four core clocks per cycle, frozen by stalls
`timescale 1ns/10ps
`default_nettype none
`include "cbt_defines.vh"
module cbt_mc_timer (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire start,
    input wire [1:0] cycles,
    input wire stall,
    // status
    output wire mc_tick,
    output wire done
);
reg run_r;
reg [1:0] phase_r;
reg [1:0] mc_r;
reg [1:0] last_r;
wire adv;
assign adv = run_r && !stall;
assign mc_tick = adv && (phase_r == `CBT_PHASE_LAST);
assign done = mc_tick && (mc_r == last_r);
always @(posedge clk or posedge rst) begin
    if (rst) begin
        run_r <= 1'b0;
        phase_r <= 2'h0;
        mc_r <= 2'h0;
        last_r <= 2'h0;
    end else if (start) begin
        run_r <= 1'b1;
        phase_r <= 2'h0;
        mc_r <= 2'h0;
        last_r <= cycles - 2'h1;
    end else if (adv) begin
        // a stall holds the phase, so the machine cycle stretches
        phase_r <= phase_r + 2'h1;
        if (mc_tick) begin
            mc_r <= mc_r + 2'h1;
        end
        if (done) begin
            run_r <= 1'b0;
        end
    end
end
endmodule
`default_nettype wire

// ==== core/cbt_core.v ====
// instruction timing and program-counter flow for transfer, bit and branch groups
// Behaviour
// - external data transfers: 1 byte, 2 cycles
// - pointer immediate load: 3 bytes, 2 cycles
// - code byte read: 1 byte, 2 cycles
// - accumulator copies take one cycle, 1/2 bytes
// - direct with register/indirect copy: 2/2
// - direct-direct or immediate-direct copy: 3/2
// - immediate into register/indirect: 2 bytes, 1 cycle
// - stack store and remove: 2/2
// - swaps take one cycle, 1/2 bytes
// - bit to carry 2/1, carry to bit 2/2
// - bit logic into carry: 2/2
// - carry ops 1/1, bit ops 2/1
// - carry branches 2/2, taken or not
// - bit branches 3/2, clear variant clears bit
// - calls, returns, jumps all take two cycles
// - indexed branch: accumulator plus pointer, 1/2
// - zero-test branches: 2/2
// - compare branch jumps on unequal: 3/2
// - count-down branch 2 or 3 bytes, 2 cycles
// - machine cycle is four clocks, stretched by stalls
// - relative offset is signed 8-bit, added
`timescale 1ns/10ps
`default_nettype none
`include "cbt_defines.vh"
module cbt_core (
    // clock and reset
    input wire MCLK,
    input wire RST,
    // instruction issue
    input wire START,
    input wire [5:0] INSN_CLASS,
    input wire [7:0] OPND1,
    input wire [7:0] OPND2,
    input wire [2:0] ADDR11_HI,
    // execution context
    input wire [7:0] ACC_VAL,
    input wire [15:0] PTR_VAL,
    input wire [15:0] RET_ADDR,
    input wire CARRY,
    input wire BIT_VAL,
    input wire CMP_NE,
    input wire [7:0] DEC_SRC,
    // prefetch stall
    input wire STALL,
    // program counter preset
    input wire PC_SET,
    input wire [15:0] PC_VALUE,
    // status and results
    output reg BUSY,
    output reg DONE,
    output reg MC_TICK,
    output reg [15:0] PC,
    output reg [1:0] INSN_LEN,
    output reg [1:0] INSN_MC,
    output reg TAKEN,
    output reg CLASS_ERR,
    output reg BIT_CLR,
    output reg CODE_RD,
    output reg [15:0] CODE_ADDR
);

////////////////////////////////////////////////////////////////////////////////
// decode and timing

wire [1:0] dec_len;
wire [1:0] dec_cycles;
wire [2:0] dec_tgt;
wire [3:0] dec_cond;
wire dec_known;
wire tmr_tick;
wire tmr_done;
wire accept;

assign accept = START && !BUSY;

cbt_decode u_decode (
    .insn_class(INSN_CLASS),
    .len(dec_len),
    .cycles(dec_cycles),
    .tgt_kind(dec_tgt),
    .cond(dec_cond),
    .known(dec_known)
);

cbt_mc_timer u_timer (
    .clk(MCLK),
    .rst(RST),
    .start(accept),
    .cycles(dec_cycles),
    .stall(STALL),
    .mc_tick(tmr_tick),
    .done(tmr_done)
);

////////////////////////////////////////////////////////////////////////////////
// operands captured at issue, so later input changes cannot disturb flow

reg [5:0] class_r;
reg [1:0] len_r;
reg [2:0] tgt_r;
reg [3:0] cond_r;
reg [7:0] op1_r;
reg [7:0] op2_r;
reg [2:0] hi3_r;
reg [7:0] acc_r;
reg [15:0] ptr_r;
reg [15:0] ret_r;
reg carry_r;
reg bit_r;
reg ne_r;
reg [7:0] dec_r;

always @(posedge MCLK or posedge RST) begin
    if (RST) begin
        class_r <= `CBT_C_IDLE;
        len_r <= `CBT_LEN1;
        tgt_r <= `CBT_T_NONE;
        cond_r <= `CBT_K_NEVER;
        op1_r <= 8'h00;
        op2_r <= 8'h00;
        hi3_r <= 3'h0;
        acc_r <= 8'h00;
        ptr_r <= 16'h0000;
        ret_r <= 16'h0000;
        carry_r <= 1'b0;
        bit_r <= 1'b0;
        ne_r <= 1'b0;
        dec_r <= 8'h00;
    end else if (accept) begin
        class_r <= INSN_CLASS;
        len_r <= dec_len;
        tgt_r <= dec_tgt;
        cond_r <= dec_cond;
        op1_r <= OPND1;
        op2_r <= OPND2;
        hi3_r <= ADDR11_HI;
        acc_r <= ACC_VAL;
        ptr_r <= PTR_VAL;
        ret_r <= RET_ADDR;
        carry_r <= CARRY;
        bit_r <= BIT_VAL;
        ne_r <= CMP_NE;
        dec_r <= DEC_SRC;
    end
end

////////////////////////////////////////////////////////////////////////////////
// next program counter

reg [15:0] pc_seq;
reg [7:0] rel_byte;
reg [15:0] rel_tgt;
reg [15:0] tgt_addr;
reg take;
reg [15:0] pc_nxt;
reg [15:0] code_nxt;

always @* begin
    pc_seq = PC + {14'h0000, len_r};
    // the offset sits last in the instruction
    rel_byte = (len_r == `CBT_LEN3) ? op2_r : op1_r;
    rel_tgt = pc_seq + {{8{rel_byte[7]}}, rel_byte};
    case (tgt_r)
        `CBT_T_REL: begin
            tgt_addr = rel_tgt;
        end
        `CBT_T_ABS11: begin
            tgt_addr = {pc_seq[15:11], hi3_r, op1_r};
        end
        `CBT_T_ABS16: begin
            tgt_addr = {op1_r, op2_r};
        end
        `CBT_T_IDX: begin
            tgt_addr = ptr_r + {8'h00, acc_r};
        end
        `CBT_T_RET: begin
            tgt_addr = ret_r;
        end
        default: begin
            tgt_addr = pc_seq;
        end
    endcase
    case (cond_r)
        `CBT_K_ALWAYS: begin
            take = 1'b1;
        end
        `CBT_K_CARRY: begin
            take = carry_r;
        end
        `CBT_K_NCARRY: begin
            take = !carry_r;
        end
        `CBT_K_BIT: begin
            take = bit_r;
        end
        `CBT_K_NBIT: begin
            take = !bit_r;
        end
        `CBT_K_ZERO: begin
            take = (acc_r == `CBT_ZERO8);
        end
        `CBT_K_NZERO: begin
            take = (acc_r != `CBT_ZERO8);
        end
        `CBT_K_NEQ: begin
            take = ne_r;
        end
        `CBT_K_COUNT_DOWN_BRANCH: begin
            take = (dec_r != `CBT_COUNT_DOWN_BRANCH_LAST);
        end
        default: begin
            take = 1'b0;
        end
    endcase
    pc_nxt = take ? tgt_addr : pc_seq;
    // program-counter relative reads use the address past the read itself
    if (class_r == `CBT_C_CODE_PC) begin
        code_nxt = pc_seq + {8'h00, acc_r};
    end else begin
        code_nxt = ptr_r + {8'h00, acc_r};
    end
end

////////////////////////////////////////////////////////////////////////////////
// next values of the registered outputs

reg is_code_rd;
reg busy_nxt;
reg done_nxt;
reg tick_nxt;
reg clr_nxt;
reg rd_nxt;
reg [15:0] pc_out_nxt;
reg taken_nxt;
reg [15:0] code_addr_nxt;

always @* begin
    is_code_rd = (class_r == `CBT_C_CODE_EXT_POINTER_REGISTER) || (class_r == `CBT_C_CODE_PC);
    // start is refused while busy, so accept and finish never meet
    busy_nxt = BUSY;
    if (accept) begin
        busy_nxt = 1'b1;
    end else if (tmr_done) begin
        busy_nxt = 1'b0;
    end
    done_nxt = tmr_done;
    tick_nxt = tmr_tick;
    // only a bit found set is cleared, once the jump is decided
    clr_nxt = tmr_done && (class_r == `CBT_C_JBC) && bit_r;
    rd_nxt = tmr_done && is_code_rd;
    pc_out_nxt = PC;
    taken_nxt = TAKEN;
    code_addr_nxt = CODE_ADDR;
    // the result beats a preset; a preset while busy is dropped
    if (tmr_done) begin
        pc_out_nxt = pc_nxt;
        taken_nxt = take;
        if (is_code_rd) begin
            code_addr_nxt = code_nxt;
        end
    end else if (PC_SET && !BUSY) begin
        pc_out_nxt = PC_VALUE;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs, all registered

always @(posedge MCLK or posedge RST) begin
    if (RST) begin
        BUSY <= 1'b0;
        DONE <= 1'b0;
        MC_TICK <= 1'b0;
        PC <= `CBT_PC_RESET;
        INSN_LEN <= `CBT_LEN1;
        INSN_MC <= `CBT_MC1;
        TAKEN <= 1'b0;
        CLASS_ERR <= 1'b0;
        BIT_CLR <= 1'b0;
        CODE_RD <= 1'b0;
        CODE_ADDR <= 16'h0000;
    end else begin
        BUSY <= busy_nxt;
        DONE <= done_nxt;
        MC_TICK <= tick_nxt;
        BIT_CLR <= clr_nxt;
        CODE_RD <= rd_nxt;
        PC <= pc_out_nxt;
        TAKEN <= taken_nxt;
        CODE_ADDR <= code_addr_nxt;
        // length and class stay up until the next accept
        if (accept) begin
            INSN_LEN <= dec_len;
            INSN_MC <= dec_cycles;
            CLASS_ERR <= !dec_known;
        end
    end
end

endmodule
`default_nettype wire

// ==== verification/cbt_core_chk.sv ====
// assertions on the ports of the instruction timing core
`timescale 1ns/10ps
`default_nettype none
module cbt_core_chk (
    // clock and reset
    input wire MCLK,
    input wire RST,
    // issue
    input wire START,
    input wire STALL,
    input wire PC_SET,
    // status
    input wire BUSY,
    input wire DONE,
    input wire MC_TICK,
    input wire [15:0] PC,
    input wire [1:0] INSN_LEN,
    input wire [1:0] INSN_MC,
    input wire TAKEN,
    input wire BIT_CLR,
    input wire CODE_RD
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    wire acc_w;
    assign acc_w = START && !BUSY;
    ////////////////////////////////////////////////////////////////////////////////
    property p_accept;
        acc_w |=> (BUSY && !DONE) ##1 (!DONE)[*3];
    endproperty
    a_accept: assert property (p_accept) else $error("accept timing wrong");
    property p_one_mc;
        acc_w ##1 (INSN_MC == 2'h1 && !STALL)[*4] |=> DONE && !BUSY;
    endproperty
    a_one_mc: assert property (p_one_mc) else $error("one cycle not four clocks");
    property p_mid_tick;
        acc_w ##1 (INSN_MC == 2'h2 && !STALL)[*4] |=> MC_TICK && !DONE;
    endproperty
    a_mid_tick: assert property (p_mid_tick) else $error("first cycle tick wrong");
    property p_two_mc;
        acc_w ##1 (INSN_MC == 2'h2 && !STALL)[*8] |=> DONE;
    endproperty
    a_two_mc: assert property (p_two_mc) else $error("two cycles not eight clocks");
    property p_stall;
        acc_w ##1 STALL ##1 (INSN_MC == 2'h1 && !STALL)[*3] ##1 !STALL |-> !DONE ##1 DONE;
    endproperty
    a_stall: assert property (p_stall) else $error("stall did not stretch");
    property p_done_end;
        DONE |-> (MC_TICK && !BUSY) ##1 !DONE;
    endproperty
    a_done_end: assert property (p_done_end) else $error("done pulse wrong");
    property p_busy_fall;
        $fell(BUSY) |-> DONE;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fell without done");
    property p_len_hold;
        BUSY && $past(BUSY) |-> $stable(INSN_LEN) && $stable(INSN_MC);
    endproperty
    a_len_hold: assert property (p_len_hold) else $error("length moved while busy");
    property p_pc_hold;
        !DONE && !($past(PC_SET) && !$past(BUSY)) |-> $stable(PC);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved between results");
    property p_bit_clr;
        BIT_CLR |-> DONE && TAKEN;
    endproperty
    a_bit_clr: assert property (p_bit_clr) else $error("bit clear without jump");
    property p_code_rd;
        CODE_RD |-> DONE && !TAKEN;
    endproperty
    a_code_rd: assert property (p_code_rd) else $error("code read strobe wrong");
    c_b2b: cover property (DONE && START);
    c_stall: cover property (BUSY && STALL);
    c_bit_clr: cover property (BIT_CLR);
endmodule
bind cbt_core cbt_core_chk u_chk (.MCLK(MCLK), .RST(RST), .START(START), .STALL(STALL),
    .PC_SET(PC_SET), .BUSY(BUSY), .DONE(DONE), .MC_TICK(MC_TICK), .PC(PC),
    .INSN_LEN(INSN_LEN), .INSN_MC(INSN_MC), .TAKEN(TAKEN), .BIT_CLR(BIT_CLR),
    .CODE_RD(CODE_RD));
`default_nettype wire

// ==== verification/tb_cpu_transfer_bit_branch_timing.sv ====
// self-checking bench for the instruction timing core
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_transfer_bit_branch_timing;
    logic MCLK = 1'b0, RST = 1'b1, START = 1'b0, STALL = 1'b0, PC_SET = 1'b0;
    logic CARRY = 1'b0, BIT_VAL = 1'b0, CMP_NE = 1'b0;
    logic [5:0] INSN_CLASS = 6'h00;
    logic [7:0] OPND1 = 8'h00, OPND2 = 8'h00, ACC_VAL = 8'h00, DEC_SRC = 8'h00;
    logic [2:0] ADDR11_HI = 3'h0;
    logic [15:0] PTR_VAL = 16'h0000, RET_ADDR = 16'h0000, PC_VALUE = 16'h0000, pm;
    wire BUSY, DONE, MC_TICK, TAKEN, CLASS_ERR, BIT_CLR, CODE_RD;
    wire [15:0] PC, CODE_ADDR;
    wire [1:0] INSN_LEN, INSN_MC;
    integer fails = 0, tests_run = 0, n;
    // {len,cycles} per sequential class, class 00 lowest
    localparam [71:0] SEQ_T = 72'h95AA995A9EA9566E65;
    localparam [15:0] FLOW_L = 16'h6E5E;
    localparam [9:0] LEN3_M = 10'h29C;
    localparam [9:0] TAKE_M = 10'h3B5;
    logic [5:0] cond_cls [0:9] = '{6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h1F, 6'h20, 6'h21,
        6'h22, 6'h23};
    cbt_core DUT (.MCLK(MCLK), .RST(RST), .START(START), .INSN_CLASS(INSN_CLASS),
        .OPND1(OPND1), .OPND2(OPND2), .ADDR11_HI(ADDR11_HI), .ACC_VAL(ACC_VAL),
        .PTR_VAL(PTR_VAL), .RET_ADDR(RET_ADDR), .CARRY(CARRY), .BIT_VAL(BIT_VAL),
        .CMP_NE(CMP_NE), .DEC_SRC(DEC_SRC), .STALL(STALL), .PC_SET(PC_SET),
        .PC_VALUE(PC_VALUE), .BUSY(BUSY), .DONE(DONE), .MC_TICK(MC_TICK), .PC(PC),
        .INSN_LEN(INSN_LEN), .INSN_MC(INSN_MC), .TAKEN(TAKEN), .CLASS_ERR(CLASS_ERR),
        .BIT_CLR(BIT_CLR), .CODE_RD(CODE_RD), .CODE_ADDR(CODE_ADDR));
    initial begin
        forever #20 MCLK = ~MCLK;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input ok, input string m);
        tests_run = tests_run + 1;
        if (ok !== 1'b1) begin
            fails = fails + 1;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // issue one instruction, stall s cycles, wait for done and judge it
    task run(input [5:0] c, input [1:0] l, m, input tk, input [15:0] t, input integer s);
        @(negedge MCLK);
        INSN_CLASS = c;
        START = 1'b1;
        @(negedge MCLK);
        START = 1'b0;
        STALL = (s > 0);
        chk(BUSY === 1'b1, "not busy");
        n = 1;
        while (DONE !== 1'b1 && n < 40) begin
            @(negedge MCLK);
            n = n + 1;
            STALL = (n <= s);
        end
        STALL = 1'b0;
        chk(n == 4 * m + s + 1, "cycles");
        chk(INSN_LEN === l && INSN_MC === m, "length");
        chk(TAKEN === tk && PC === (tk ? t : pm + l), "flow");
        pm = tk ? t : pm + l;
    endtask
    task set_pc(input [15:0] v);
        @(negedge MCLK);
        PC_SET = 1'b1;
        PC_VALUE = v;
        @(negedge MCLK);
        PC_SET = 1'b0;
        chk(PC === v, "preset");
        pm = v;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk(PC === 16'h0000 && BUSY === 1'b0 && DONE === 1'b0, "reset state");
        chk(INSN_LEN === 2'h1 && INSN_MC === 2'h1 && TAKEN === 1'b0, "reset length");
        $display("test reset done");
    endtask
    // sequential classes from near the top of memory, so the pc wraps
    task t_seq;
        integer i;
        logic [3:0] e;
        logic [15:0] pb;
        ACC_VAL = 8'h9C;
        PTR_VAL = 16'h12F0;
        for (i = 0; i < 18; i = i + 1) begin
            e = SEQ_T[i*4 +: 4];
            pb = pm;
            run(i[5:0], e[3:2], e[1:0], 1'b0, 16'h0000, 0);
            chk(CODE_RD === (i == 3 || i == 4), "code strobe");
            if (i == 3 || i == 4)
                chk(CODE_ADDR === (i == 3 ? 16'h138C : pb + 16'h009D), "code addr");
        end
        $display("test sequential done");
    endtask
    // every conditional branch both ways, backward and forward offsets
    task t_cond;
        integer i, k;
        logic tk;
        logic [1:0] l;
        logic [15:0] t;
        OPND1 = 8'hF0;
        OPND2 = 8'h7F;
        for (k = 0; k < 2; k = k + 1) begin
            CARRY = ~k[0];
            BIT_VAL = ~k[0];
            CMP_NE = ~k[0];
            ACC_VAL = k[0] ? 8'h05 : 8'h00;
            DEC_SRC = k[0] ? 8'h01 : 8'h00;
            for (i = 0; i < 10; i = i + 1) begin
                l = LEN3_M[i] ? 2'h3 : 2'h2;
                tk = TAKE_M[i] ^ k[0];
                t = pm + l + (l == 2'h3 ? 16'h007F : 16'hFFF0);
                run(cond_cls[i], l, 2'h2, tk, t, 0);
                chk(BIT_CLR === (tk && i == 4), "bit clear");
            end
        end
        $display("test conditional done");
    endtask
    task t_jump;
        integer i;
        logic [1:0] l;
        logic [15:0] t;
        OPND1 = 8'h34;
        OPND2 = 8'h56;
        ADDR11_HI = 3'h5;
        RET_ADDR = 16'hA55A;
        ACC_VAL = 8'h80;
        PTR_VAL = 16'hFFC0;
        for (i = 0; i < 8; i = i + 1) begin
            l = FLOW_L[i*2 +: 2];
            t = pm + l;
            case (i)
                0, 4: t = {t[15:11], 3'h5, 8'h34};
                1, 5: t = 16'h3456;
                2, 3: t = 16'hA55A;
                6: t = t + 16'h0034;
                default: t = 16'h0040;
            endcase
            run(6'h17 + i[5:0], l, 2'h2, 1'b1, t, 0);
        end
        $display("test jumps done");
    endtask
    task t_stall;
        run(6'h01, 2'h1, 2'h2, 1'b0, 16'h0000, 3);
        run(6'h00, 2'h1, 2'h1, 1'b0, 16'h0000, 1);
        $display("test stall done");
    endtask
    // start held high: second issue lands on the done cycle; preset while busy is lost
    task t_b2b;
        @(negedge MCLK);
        INSN_CLASS = 6'h00;
        START = 1'b1;
        @(negedge MCLK);
        INSN_CLASS = 6'h06;
        PC_SET = 1'b1;
        PC_VALUE = 16'h1234;
        @(negedge MCLK);
        PC_SET = 1'b0;
        repeat (3) @(negedge MCLK);
        chk(DONE === 1'b1 && PC === pm + 16'h0001, "first of pair");
        @(negedge MCLK);
        START = 1'b0;
        chk(BUSY === 1'b1 && INSN_LEN === 2'h2, "second accept");
        repeat (4) @(negedge MCLK);
        chk(DONE === 1'b1 && PC === pm + 16'h0003, "second of pair");
        pm = pm + 16'h0003;
        $display("test back to back done");
    endtask
    task t_err;
        run(6'h3F, 2'h1, 2'h1, 1'b0, 16'h0000, 0);
        chk(CLASS_ERR === 1'b1, "unknown class");
        run(6'h10, 2'h1, 2'h1, 1'b0, 16'h0000, 0);
        chk(CLASS_ERR === 1'b0, "error held");
        $display("test unknown class done");
    endtask
    task t_rst_mid;
        @(negedge MCLK);
        INSN_CLASS = 6'h02;
        START = 1'b1;
        @(negedge MCLK);
        START = 1'b0;
        RST = 1'b1;
        @(negedge MCLK);
        chk(BUSY === 1'b0 && PC === 16'h0000 && INSN_MC === 2'h1, "mid reset");
        RST = 1'b0;
        pm = 16'h0000;
        run(6'h00, 2'h1, 2'h1, 1'b0, 16'h0000, 0);
        $display("test mid reset done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge MCLK);
        RST = 1'b0;
        t_reset;
        set_pc(16'hFFF8);
        t_seq;
        t_cond;
        t_jump;
        t_stall;
        t_b2b;
        t_err;
        t_rst_mid;
        complete_run;
    end
    // about 500 cycles expected; generous margin
    initial begin
        #(40 * 5000);
        fails = fails + 1;
        complete_run;
    end
endmodule
`default_nettype wire
